// file: tpstc_pkg.sv
// Purpose: Shared constants and types for the touch panel scan timing block.
// Assumes: 40 MHz system clock; registers sit at word indices on Avalon-MM.
// Notes: Each printed register offset is a word index; byte address is four times it.
package tpstc_pkg;
  // ----------------------------------------
  // Register word indices
  // ----------------------------------------
  localparam logic [29:0] SAMPLE_INTERVAL_IDX = 30'h0b000126;
  localparam logic [29:0] SETTLE_TIME_IDX = 30'h0b000128;
  localparam logic [29:0] COMMAND_SCAN_SETUP_IDX = 30'h0b00012a;
  localparam logic [29:0] EVENT_STATUS_IDX = 30'h0b000140;
  localparam logic [29:0] EVENT_ENABLE_IDX = 30'h0b000141;
  localparam logic [29:0] EVENT_CLEAR_IDX = 30'h0b000142;
  localparam logic [29:0] SCAN_CONTROL_IDX = 30'h0b000143;
  // ----------------------------------------
  // Reset values and writable masks
  // ----------------------------------------
  localparam logic [15:0] SAMPLE_INTERVAL_RST = 16'h0007;
  localparam logic [15:0] SETTLE_TIME_RST = 16'h0007;
  localparam logic [15:0] COMMAND_SCAN_SETUP_RST = 16'h000f;
  localparam logic [15:0] SAMPLE_INTERVAL_MASK = 16'h07ff;
  localparam logic [15:0] SETTLE_TIME_MASK = 16'h003f;
  localparam logic [15:0] COMMAND_SCAN_SETUP_MASK = 16'h1fff;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int INTERVAL_W = 11;
  localparam int SETTLE_W = 6;
  localparam int SETTLE_EN_BIT = 12;
  localparam int Y_DIR_LSB = 10;
  localparam int X_DIR_LSB = 8;
  localparam int Y_LVL_LSB = 6;
  localparam int X_LVL_LSB = 4;
  localparam int ADC_SEL_LSB = 0;
  localparam logic [3:0] ADC_SEL_STANDBY = 4'hf;
  localparam int EVT_W = 3;
  localparam int EVT_AUX_DONE_BIT = 0;
  localparam int EVT_TIMEOUT_BIT = 2;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_AUX_START_BIT = 1;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 25000;
  localparam int TICK_PS = 30000000;
  localparam int TICK_CYCLES = TICK_PS / CLK_PERIOD_PS;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETTLE = 2'b01,
    ST_CONVERT = 2'b10,
    ST_AUX = 2'b11
  } tpstc_state_t;
endpackage

// file: tpstc_scan_timing.sv
// Purpose: Scan timing, command scan pin setup and converter select for a touch panel.
// Assumes: Sequencer strobes come from logic on the same clock, so no synchronisers.
// Notes: Registers are reached over Avalon-MM with one wait cycle per access.
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ps
module tpstc_scan_timing #(
  parameter int TICK_CYCLES = tpstc_pkg::TICK_CYCLES
) (
  // Clock and resets
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_clock_unit_reset,
  // Avalon-MM slave
  input wire logic [29:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Sequencer handshakes
  input wire logic i_pair_done,
  input wire logic i_cmd_scan_start,
  input wire logic i_conv_done,
  input wire logic i_aux_scan_done,
  output logic o_sample_start,
  output logic o_convert_start,
  output logic o_cmd_scan_active,
  output logic o_aux_scan_busy,
  // Panel pins and converter
  output logic [1:0] o_x_pin_out,
  output logic [1:0] o_x_pin_oe,
  output logic [1:0] o_y_pin_out,
  output logic [1:0] o_y_pin_oe,
  output logic [3:0] o_adc_sel,
  output logic o_adc_standby,
  // Interrupt
  output logic o_irq
);
  // ----------------------------------------
  // Resets and bus slave
  // ----------------------------------------
  localparam int TW = $clog2(TICK_CYCLES);
  logic soft_rst;
  logic waitreq_ff;
  logic [31:0] rdata_ff;
  logic wr_en;
  logic [31:0] rd_mux;
  logic [15:0] sample_interval_ff;
  logic [15:0] settle_time_ff;
  logic [15:0] cmd_setup_ff;
  logic [tpstc_pkg::EVT_W-1:0] status_ff;
  logic [tpstc_pkg::EVT_W-1:0] irq_en_ff;
  logic [tpstc_pkg::EVT_W-1:0] evt_clr;
  logic [tpstc_pkg::EVT_W-1:0] evt_set;
  logic [tpstc_pkg::EVT_W-1:0] nxt_status;
  logic run_ff;
  logic aux_start_ff;

  assign soft_rst = !i_rst_b || i_clock_unit_reset;
  assign wr_en = i_avs_write && !waitreq_ff;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                        input logic [3:0] be, input logic [15:0] mask);
    logic [15:0] res;
    res = old;
    if (be[0]) begin
      res[7:0] = wd[7:0];
    end
    if (be[1]) begin
      res[15:8] = wd[15:8];
    end
    merge = res & mask;
  endfunction

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (i_avs_address == tpstc_pkg::SAMPLE_INTERVAL_IDX) begin
      rd_mux = {16'h0000, sample_interval_ff};
    end else if (i_avs_address == tpstc_pkg::SETTLE_TIME_IDX) begin
      rd_mux = {16'h0000, settle_time_ff};
    end else if (i_avs_address == tpstc_pkg::COMMAND_SCAN_SETUP_IDX) begin
      rd_mux = {16'h0000, cmd_setup_ff};
    end else if (i_avs_address == tpstc_pkg::EVENT_STATUS_IDX) begin
      rd_mux = {29'h0000_0000, status_ff};
    end else if (i_avs_address == tpstc_pkg::EVENT_ENABLE_IDX) begin
      rd_mux = {29'h0000_0000, irq_en_ff};
    end else if (i_avs_address == tpstc_pkg::SCAN_CONTROL_IDX) begin
      rd_mux = {30'h0000_0000, aux_start_ff, run_ff};
    end
  end

  // One wait cycle: read data is captured as waitrequest falls.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      waitreq_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end else if ((i_avs_read || i_avs_write) && waitreq_ff) begin
      waitreq_ff <= 1'b0;
      rdata_ff <= i_avs_read ? rd_mux : 32'h0000_0000;
    end else begin
      waitreq_ff <= 1'b1;
    end
  end

  assign o_avs_waitrequest = waitreq_ff;
  assign o_avs_readdata = rdata_ff;

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (soft_rst) begin
      sample_interval_ff <= tpstc_pkg::SAMPLE_INTERVAL_RST;
      settle_time_ff <= tpstc_pkg::SETTLE_TIME_RST;
      cmd_setup_ff <= tpstc_pkg::COMMAND_SCAN_SETUP_RST;
      irq_en_ff <= '0;
      run_ff <= 1'b0;
    end else if (wr_en) begin
      if (i_avs_address == tpstc_pkg::SAMPLE_INTERVAL_IDX) begin
        sample_interval_ff <= merge(sample_interval_ff, i_avs_writedata, i_avs_byteenable,
                                    tpstc_pkg::SAMPLE_INTERVAL_MASK);
      end else if (i_avs_address == tpstc_pkg::SETTLE_TIME_IDX) begin
        settle_time_ff <= merge(settle_time_ff, i_avs_writedata, i_avs_byteenable,
                                tpstc_pkg::SETTLE_TIME_MASK);
      end else if (i_avs_address == tpstc_pkg::COMMAND_SCAN_SETUP_IDX) begin
        cmd_setup_ff <= merge(cmd_setup_ff, i_avs_writedata, i_avs_byteenable,
                              tpstc_pkg::COMMAND_SCAN_SETUP_MASK);
      end else if (i_avs_address == tpstc_pkg::EVENT_ENABLE_IDX && i_avs_byteenable[0]) begin
        irq_en_ff <= i_avs_writedata[tpstc_pkg::EVT_W-1:0];
      end else if (i_avs_address == tpstc_pkg::SCAN_CONTROL_IDX && i_avs_byteenable[0]) begin
        run_ff <= i_avs_writedata[tpstc_pkg::CTRL_RUN_BIT];
      end
    end
  end

  // ----------------------------------------
  // 30 us tick
  // ----------------------------------------
  logic [TW-1:0] tick_cnt_ff;
  logic tick_ff;

  always_ff @(posedge i_sys_clk) begin
    if (soft_rst) begin
      tick_cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else if (tick_cnt_ff == TW'(TICK_CYCLES - 1)) begin
      tick_cnt_ff <= '0;
      tick_ff <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 1'b1;
      tick_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // Coordinate sampling interval
  // ----------------------------------------
  logic [tpstc_pkg::INTERVAL_W-1:0] intvl_cnt_ff;
  logic [tpstc_pkg::INTERVAL_W-1:0] intvl_val;
  logic acq_busy_ff;
  logic overrun_ff;
  logic sample_start_ff;
  logic busy_now;
  logic overrun_evt;

  assign intvl_val = sample_interval_ff[tpstc_pkg::INTERVAL_W-1:0];
  assign busy_now = acq_busy_ff && !i_pair_done;
  // An interval that expires while the pair is still in progress is lost data.
  assign overrun_evt = run_ff && intvl_cnt_ff == '0 && busy_now && intvl_val != '0
                       && !overrun_ff;

  always_ff @(posedge i_sys_clk) begin
    if (soft_rst) begin
      intvl_cnt_ff <= '0;
      acq_busy_ff <= 1'b0;
      overrun_ff <= 1'b0;
      sample_start_ff <= 1'b0;
    end else begin
      sample_start_ff <= 1'b0;
      if (i_pair_done) begin
        acq_busy_ff <= 1'b0;
      end
      if (overrun_evt) begin
        overrun_ff <= 1'b1;
      end
      if (!run_ff) begin
        intvl_cnt_ff <= '0;
      end else if (intvl_cnt_ff == '0) begin
        if (!busy_now) begin
          sample_start_ff <= 1'b1;
          acq_busy_ff <= 1'b1;
          overrun_ff <= 1'b0;
          intvl_cnt_ff <= intvl_val;
        end
      end else if (tick_ff) begin
        intvl_cnt_ff <= intvl_cnt_ff - 1'b1;
      end
    end
  end

  assign o_sample_start = sample_start_ff;

  // ----------------------------------------
  // Settling, command scan and auxiliary scan
  // ----------------------------------------
  tpstc_pkg::tpstc_state_t state_ff;
  tpstc_pkg::tpstc_state_t nxt_state;
  logic [tpstc_pkg::SETTLE_W-1:0] settle_cnt_ff;
  logic [tpstc_pkg::SETTLE_W-1:0] nxt_settle_cnt;
  logic [tpstc_pkg::SETTLE_W-1:0] settle_val;
  logic settle_en;
  logic nxt_convert_start;
  logic aux_done_evt;
  logic aux_timeout_evt;
  logic convert_start_ff;

  assign settle_val = settle_time_ff[tpstc_pkg::SETTLE_W-1:0];
  assign settle_en = cmd_setup_ff[tpstc_pkg::SETTLE_EN_BIT];

  always_comb begin
    nxt_state = state_ff;
    nxt_settle_cnt = settle_cnt_ff;
    nxt_convert_start = 1'b0;
    aux_done_evt = 1'b0;
    aux_timeout_evt = 1'b0;
    case (state_ff)
      tpstc_pkg::ST_IDLE: begin
        if (i_cmd_scan_start) begin
          if (settle_en && settle_val != '0) begin
            nxt_state = tpstc_pkg::ST_SETTLE;
            nxt_settle_cnt = settle_val;
          end else begin
            nxt_state = tpstc_pkg::ST_CONVERT;
            nxt_convert_start = 1'b1;
          end
        end else if (aux_start_ff) begin
          nxt_state = tpstc_pkg::ST_AUX;
          nxt_settle_cnt = settle_val;
        end
      end
      tpstc_pkg::ST_SETTLE: begin
        if (settle_cnt_ff == '0) begin
          nxt_state = tpstc_pkg::ST_CONVERT;
          nxt_convert_start = 1'b1;
        end else if (tick_ff) begin
          nxt_settle_cnt = settle_cnt_ff - 1'b1;
        end
      end
      tpstc_pkg::ST_CONVERT: begin
        if (i_conv_done) begin
          nxt_state = tpstc_pkg::ST_IDLE;
        end
      end
      tpstc_pkg::ST_AUX: begin
        if (i_aux_scan_done) begin
          nxt_state = tpstc_pkg::ST_IDLE;
          aux_done_evt = 1'b1;
        end else if (settle_cnt_ff == '0) begin
          nxt_state = tpstc_pkg::ST_IDLE;
          aux_timeout_evt = 1'b1;
        end else if (tick_ff) begin
          nxt_settle_cnt = settle_cnt_ff - 1'b1;
        end
      end
      default: begin
        nxt_state = tpstc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (soft_rst) begin
      state_ff <= tpstc_pkg::ST_IDLE;
      settle_cnt_ff <= '0;
      convert_start_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      settle_cnt_ff <= nxt_settle_cnt;
      convert_start_ff <= nxt_convert_start;
    end
  end

  // The start bit clears itself when the auxiliary scan ends.
  always_ff @(posedge i_sys_clk) begin
    if (soft_rst) begin
      aux_start_ff <= 1'b0;
    end else if (state_ff == tpstc_pkg::ST_AUX && nxt_state == tpstc_pkg::ST_IDLE) begin
      aux_start_ff <= 1'b0;
    end else if (wr_en && i_avs_address == tpstc_pkg::SCAN_CONTROL_IDX && i_avs_byteenable[0]
                 && i_avs_writedata[tpstc_pkg::CTRL_AUX_START_BIT]) begin
      aux_start_ff <= 1'b1;
    end
  end

  // ----------------------------------------
  // Panel pins and converter select
  // ----------------------------------------
  logic cmd_active_ff;
  logic aux_busy_ff;
  logic nxt_cmd_active;
  logic [1:0] x_dir;
  logic [1:0] y_dir;
  logic [1:0] x_out_ff;
  logic [1:0] x_oe_ff;
  logic [1:0] y_out_ff;
  logic [1:0] y_oe_ff;
  logic [3:0] adc_sel_ff;
  logic adc_standby_ff;
  logic [3:0] adc_code;

  assign nxt_cmd_active = nxt_state == tpstc_pkg::ST_SETTLE
                          || nxt_state == tpstc_pkg::ST_CONVERT;
  assign x_dir = cmd_setup_ff[tpstc_pkg::X_DIR_LSB +: 2];
  assign y_dir = cmd_setup_ff[tpstc_pkg::Y_DIR_LSB +: 2];
  assign adc_code = cmd_setup_ff[tpstc_pkg::ADC_SEL_LSB +: 4];

  always_ff @(posedge i_sys_clk) begin
    if (soft_rst) begin
      cmd_active_ff <= 1'b0;
      aux_busy_ff <= 1'b0;
      x_oe_ff <= 2'h0;
      y_oe_ff <= 2'h0;
      x_out_ff <= 2'h0;
      y_out_ff <= 2'h0;
      adc_sel_ff <= tpstc_pkg::ADC_SEL_STANDBY;
      adc_standby_ff <= 1'b1;
    end else begin
      cmd_active_ff <= nxt_cmd_active;
      aux_busy_ff <= nxt_state == tpstc_pkg::ST_AUX;
      x_oe_ff <= nxt_cmd_active ? x_dir : 2'h0;
      y_oe_ff <= nxt_cmd_active ? y_dir : 2'h0;
      x_out_ff <= nxt_cmd_active ? cmd_setup_ff[tpstc_pkg::X_LVL_LSB +: 2] & x_dir : 2'h0;
      y_out_ff <= nxt_cmd_active ? cmd_setup_ff[tpstc_pkg::Y_LVL_LSB +: 2] & y_dir : 2'h0;
      adc_sel_ff <= adc_code;
      adc_standby_ff <= adc_code == tpstc_pkg::ADC_SEL_STANDBY;
    end
  end

  assign o_cmd_scan_active = cmd_active_ff;
  assign o_aux_scan_busy = aux_busy_ff;
  assign o_convert_start = convert_start_ff;
  assign o_x_pin_oe = x_oe_ff;
  assign o_y_pin_oe = y_oe_ff;
  assign o_x_pin_out = x_out_ff;
  assign o_y_pin_out = y_out_ff;
  assign o_adc_sel = adc_sel_ff;
  assign o_adc_standby = adc_standby_ff;

  // ----------------------------------------
  // Event status and interrupt
  // ----------------------------------------
  logic irq_ff;

  always_comb begin
    evt_set = '0;
    evt_set[tpstc_pkg::EVT_TIMEOUT_BIT] = overrun_evt || aux_timeout_evt;
    evt_set[tpstc_pkg::EVT_AUX_DONE_BIT] = aux_done_evt;
    evt_clr = '0;
    if (wr_en && i_avs_address == tpstc_pkg::EVENT_CLEAR_IDX && i_avs_byteenable[0]) begin
      evt_clr = i_avs_writedata[tpstc_pkg::EVT_W-1:0];
    end
    nxt_status = (status_ff & ~evt_clr) | evt_set;
  end

  always_ff @(posedge i_sys_clk) begin
    if (soft_rst) begin
      status_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      irq_ff <= |(nxt_status & irq_en_ff);
    end
  end

  assign o_irq = irq_ff;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_tick_period;
    @(posedge i_sys_clk) disable iff (soft_rst)
      tick_ff |-> $past(tick_cnt_ff) == TW'(TICK_CYCLES - 1);
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("tick spacing wrong");
  property p_interval_reload;
    @(posedge i_sys_clk) disable iff (soft_rst)
      o_sample_start |-> intvl_cnt_ff == $past(intvl_val);
  endproperty
  a_interval_reload: assert property (p_interval_reload) else $error("interval not loaded");
  property p_input_ignores_level;
    @(posedge i_sys_clk) disable iff (soft_rst)
      ((o_x_pin_out & ~o_x_pin_oe) == 2'h0) && ((o_y_pin_out & ~o_y_pin_oe) == 2'h0);
  endproperty
  a_input_ignores_level: assert property (p_input_ignores_level) else $error("input pin driven");
  property p_x_dir;
    @(posedge i_sys_clk) disable iff (soft_rst)
      $rose(o_cmd_scan_active) |-> o_x_pin_oe == $past(x_dir);
  endproperty
  a_x_dir: assert property (p_x_dir) else $error("x direction mismatch");
  property p_y_dir;
    @(posedge i_sys_clk) disable iff (soft_rst)
      $rose(o_cmd_scan_active) |-> o_y_pin_oe == $past(y_dir);
  endproperty
  a_y_dir: assert property (p_y_dir) else $error("y direction mismatch");
  property p_no_settle;
    @(posedge i_sys_clk) disable iff (soft_rst)
      (state_ff == tpstc_pkg::ST_IDLE && i_cmd_scan_start && !settle_en) |=> o_convert_start;
  endproperty
  a_no_settle: assert property (p_no_settle) else $error("settle not bypassed");
  property p_settle_end;
    @(posedge i_sys_clk) disable iff (soft_rst)
      (state_ff == tpstc_pkg::ST_SETTLE && settle_cnt_ff == '0) |=> o_convert_start;
  endproperty
  a_settle_end: assert property (p_settle_end) else $error("conversion not started");
  property p_aux_timeout;
    @(posedge i_sys_clk) disable iff (soft_rst)
      (state_ff == tpstc_pkg::ST_AUX && settle_cnt_ff == '0 && !i_aux_scan_done)
      |=> status_ff[tpstc_pkg::EVT_TIMEOUT_BIT];
  endproperty
  a_aux_timeout: assert property (p_aux_timeout) else $error("aux timeout not flagged");
  property p_flag_sticky;
    @(posedge i_sys_clk) disable iff (soft_rst)
      (status_ff[tpstc_pkg::EVT_TIMEOUT_BIT] && !evt_clr[tpstc_pkg::EVT_TIMEOUT_BIT])
      |=> status_ff[tpstc_pkg::EVT_TIMEOUT_BIT];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("timeout flag lost");
endmodule

// file: tpstc_panel_model.sv
// Purpose: Behavioural touch panel and converter facing the scan timing block.
// Assumes: Delays come from the bench; a zero aux delay means the port scan never ends.
// Notes: Every answer is a one-cycle pulse a set number of cycles after its request.
`timescale 1ns/1ps
module tpstc_panel_model (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // Requests and answer delays
  input wire logic i_sample_start,
  input wire logic i_convert_start,
  input wire logic i_aux_scan_busy,
  input wire logic [15:0] i_pair_delay,
  input wire logic [15:0] i_conv_delay,
  input wire logic [15:0] i_aux_delay,
  // Answers
  output logic o_pair_done,
  output logic o_conv_done,
  output logic o_aux_scan_done
);
  logic [15:0] pair_ff;
  logic [15:0] conv_ff;
  logic [15:0] aux_ff;
  logic busy_ff;
  // A slow pair answer lets the interval run out while busy.
  always_ff @(posedge i_sys_clk) begin
    busy_ff <= i_aux_scan_busy;
    o_pair_done <= i_rst_b && pair_ff == 16'h0001;
    o_conv_done <= i_rst_b && conv_ff == 16'h0001;
    o_aux_scan_done <= i_rst_b && aux_ff == 16'h0001;
    if (!i_rst_b) begin
      pair_ff <= 16'h0000;
      conv_ff <= 16'h0000;
      aux_ff <= 16'h0000;
    end else begin
      pair_ff <= i_sample_start ? i_pair_delay : pair_ff - 16'(pair_ff != 16'h0000);
      conv_ff <= i_convert_start ? i_conv_delay : conv_ff - 16'(conv_ff != 16'h0000);
      aux_ff <= (i_aux_scan_busy && !busy_ff) ? i_aux_delay : aux_ff - 16'(aux_ff != 16'h0000);
    end
  end
endmodule

// file: touch_panel_scan_timing_command_bench.sv
// Purpose: Self-checking bench for the touch panel scan timing block.
// Assumes: Tick shortened to four cycles; the panel model answers the sequencer strobes.
// Notes: Expected read values are queued by rd_exp and compared by a monitor.
`timescale 1ns/1ps
module touch_panel_scan_timing_command_bench;
  localparam int TK = 4;
  logic i_sys_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic clk_rst = 1'b0;
  logic [29:0] addr = 30'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'h3;
  logic cmd_start = 1'b0;
  logic pair_done, conv_done, aux_done, wait_req, smp, cvt, act, abusy, stby, irq;
  logic [31:0] rdata;
  logic [1:0] xo, xoe, yo, yoe;
  logic [3:0] sel;
  logic [15:0] pdly = 16'h0002;
  logic [15:0] adly = 16'h0002;
  int miscompares = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [31:0] exp_q[$];
  logic [31:0] seed = 32'h0000c2ad;

  tpstc_scan_timing #(.TICK_CYCLES(TK)) dut (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
    .i_clock_unit_reset(clk_rst), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_req), .i_pair_done(pair_done), .i_cmd_scan_start(cmd_start),
    .i_conv_done(conv_done), .i_aux_scan_done(aux_done), .o_sample_start(smp),
    .o_convert_start(cvt), .o_cmd_scan_active(act), .o_aux_scan_busy(abusy),
    .o_x_pin_out(xo), .o_x_pin_oe(xoe), .o_y_pin_out(yo), .o_y_pin_oe(yoe),
    .o_adc_sel(sel), .o_adc_standby(stby), .o_irq(irq));
  tpstc_panel_model panel (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_sample_start(smp),
    .i_convert_start(cvt), .i_aux_scan_busy(abusy), .i_pair_delay(pdly),
    .i_conv_delay(16'h0003), .i_aux_delay(adly), .o_pair_done(pair_done),
    .o_conv_done(conv_done), .o_aux_scan_done(aux_done));

  always #12.5 i_sys_clk = ~i_sys_clk;

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
    samples_checked++;
    if (got !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, got);
    end
  endtask
  task automatic bus(input logic [29:0] a, input logic w, input logic [15:0] d);
    @(posedge i_sys_clk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= {16'h0000, d};
    do @(posedge i_sys_clk); while (wait_req !== 1'b0);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rd_exp(input logic [29:0] a, input logic [15:0] e);
    exp_q.push_back({16'h0000, e});
    bus(a, 1'b0, 16'h0000);
  endtask
  task automatic wait_sig(ref logic s, output int n);
    n = 0;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (s !== 1'b1);
  endtask
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  always @(posedge i_sys_clk) begin
    if (rd && wait_req === 1'b0) chk("readdata", exp_q.pop_front(), rdata);
  end
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      miscompares++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [29:0] ra[3];
    logic [15:0] rm[3];
    logic [3:0] codes[9];
    logic [31:0] r;
    int n, k, lo, hi;
    ra = '{tpstc_pkg::SAMPLE_INTERVAL_IDX, tpstc_pkg::SETTLE_TIME_IDX,
      tpstc_pkg::COMMAND_SCAN_SETUP_IDX};
    rm = '{tpstc_pkg::SAMPLE_INTERVAL_MASK, tpstc_pkg::SETTLE_TIME_MASK,
      tpstc_pkg::COMMAND_SCAN_SETUP_MASK};
    codes = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hf};
    repeat (10) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    rd_exp(ra[0], 16'h0007);
    rd_exp(ra[1], 16'h0007);
    rd_exp(ra[2], 16'h000f);
    chk("standby", 32'h1, stby);
    bus(30'h0b000130, 1'b1, 16'hffff);
    rd_exp(30'h0b000130, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      bus(ra[i], 1'b1, 16'hffff);
      rd_exp(ra[i], rm[i]);
    end
    $display("test registers done");
    for (int i = 0; i < 9; i++) begin
      k = i % 3;
      r = rnd();
      lo = (k == 2) ? TK + 1 : 1;
      hi = (k == 2) ? 2 * TK + 2 : 1;
      bus(ra[1], 1'b1, (k == 1) ? 16'h0000 : 16'h0002);
      bus(ra[2], 1'b1, {3'b000, k != 0, r[11:4], codes[i]});
      @(posedge i_sys_clk) cmd_start <= 1'b1;
      @(posedge i_sys_clk) cmd_start <= 1'b0;
      wait_sig(cvt, n);
      chk("settle_cycles", 32'h1, n >= lo && n <= hi);
      chk("x_oe", r[9:8], xoe);
      chk("y_oe", r[11:10], yoe);
      chk("x_out", r[5:4] & r[9:8], xo);
      chk("y_out", r[7:6] & r[11:10], yo);
      chk("adc_sel", codes[i], sel);
      chk("standby", codes[i] == 4'hf, stby);
      chk("cmd_active", 32'h1, act);
      repeat (8) @(posedge i_sys_clk);
      chk("pins_idle", 32'h0, {xoe, yoe, act});
    end
    $display("test command scan done");
    bus(ra[0], 1'b1, 16'h0003);
    bus(tpstc_pkg::EVENT_ENABLE_IDX, 1'b1, 16'h0004);
    bus(tpstc_pkg::SCAN_CONTROL_IDX, 1'b1, 16'h0001);
    wait_sig(smp, n);
    wait_sig(smp, n);
    chk("sample_gap", 32'h1, n >= 2 * TK + 1 && n <= 3 * TK + 2);
    bus(ra[0], 1'b1, 16'h0000);
    wait_sig(smp, n);
    wait_sig(smp, n);
    chk("zero_gap", 32'h1, n <= 6);
    rd_exp(tpstc_pkg::EVENT_STATUS_IDX, 16'h0000);
    pdly <= 16'h0028;
    bus(ra[0], 1'b1, 16'h0003);
    repeat (60) @(posedge i_sys_clk);
    chk("irq_timeout", 32'h1, irq);
    bus(tpstc_pkg::SCAN_CONTROL_IDX, 1'b1, 16'h0000);
    repeat (50) @(posedge i_sys_clk);
    rd_exp(tpstc_pkg::EVENT_STATUS_IDX, 16'h0004);
    bus(tpstc_pkg::EVENT_ENABLE_IDX, 1'b1, 16'h0000);
    repeat (2) @(posedge i_sys_clk);
    chk("irq_masked", 32'h0, irq);
    bus(tpstc_pkg::EVENT_ENABLE_IDX, 1'b1, 16'h0004);
    bus(tpstc_pkg::EVENT_CLEAR_IDX, 1'b1, 16'h0004);
    repeat (2) @(posedge i_sys_clk);
    chk("irq_cleared", 32'h0, irq);
    rd_exp(tpstc_pkg::EVENT_STATUS_IDX, 16'h0000);
    $display("test sampling done");
    adly <= 16'h0000;
    bus(ra[1], 1'b1, 16'h0002);
    bus(tpstc_pkg::SCAN_CONTROL_IDX, 1'b1, 16'h0002);
    repeat (2) @(posedge i_sys_clk);
    chk("aux_busy", 32'h1, abusy);
    repeat (18) @(posedge i_sys_clk);
    chk("aux_timeout", 32'h1, irq);
    rd_exp(tpstc_pkg::SCAN_CONTROL_IDX, 16'h0000);
    bus(tpstc_pkg::EVENT_CLEAR_IDX, 1'b1, 16'h0005);
    adly <= 16'h0002;
    bus(tpstc_pkg::EVENT_ENABLE_IDX, 1'b1, 16'h0005);
    bus(tpstc_pkg::SCAN_CONTROL_IDX, 1'b1, 16'h0002);
    repeat (20) @(posedge i_sys_clk);
    rd_exp(tpstc_pkg::EVENT_STATUS_IDX, 16'h0001);
    $display("test aux scan done");
    bus(ra[0], 1'b1, 16'h0005);
    @(posedge i_sys_clk) clk_rst <= 1'b1;
    @(posedge i_sys_clk) clk_rst <= 1'b0;
    rd_exp(ra[0], 16'h0007);
    $display("test second reset done");
    repeat (2) @(posedge i_sys_clk);
    report_and_stop();
  end
endmodule
